// [rtl/msc_pkg.sv]
// Package for the modem select and chirp parameter block: codes, limits, reset values.
// Assumes a single 100 MHz clock and commands decoded elsewhere into one-cycle pulses.
// Operation
// (RL1) Packet type picks frame and modem.
// (RL2) Host selects packet type before anything else.
// (RL3) Read command reports current packet type.
// (RL4) Hopping mode: modulator only, no packet handler.
// (RL5) Host loads modulation only after type selection.
// (RL6) Spread factor 5 to 12, 2^SF chips.
// (RL7) Spread factors five, six allow both headers.
// (RL8) Host should use 12-symbol preamble there.
// (RL9) Both link ends use the same factor.
// (RL10) Symbol rate is bandwidth over 2^SF.
// (RL11) Bandwidth codes 0-9 map to table.
// (RL12) Below 400 MHz, top two bandwidths refused.
// (RL13) 500 kHz uses zero-IF, others low-IF.
// (RL14) Code rates 1-4 give 4/5..4/8.
// (RL15) Receiver takes code rate from header.
// (RL16) Optimization carries spread factor minus two.
// (RL17) Host enables optimization at long symbols.
// (RL18) Host prefers code rate 4/5 normally.
// (RL19) Explicit header sent at rate 4/8.
// (RL20) Settings hold until the next command.
package msc_pkg;
  localparam longint MSC_CLK_HZ = 100_000_000;
  localparam logic [1:0] MSC_PT_FSK = 2'h0;
  localparam logic [1:0] MSC_PT_CSS = 2'h1;
  localparam logic [1:0] MSC_PT_NONE = 2'h2;
  localparam logic [1:0] MSC_PT_HOP = 2'h3;
  localparam logic [3:0] MSC_SF_MIN = 4'h5;
  localparam logic [3:0] MSC_SF_MAX = 4'hC;
  localparam logic [3:0] MSC_BW_MAX = 4'h9;
  localparam logic [3:0] MSC_BW_LOW_LIMIT = 4'h8;
  localparam logic [3:0] MSC_BW_ZERO_IF = 4'h9;
  localparam logic [2:0] MSC_CR_MIN = 3'h1;
  localparam logic [2:0] MSC_CR_MAX = 3'h4;
  localparam logic [2:0] MSC_HDR_CR = 3'h4;
  localparam logic [3:0] MSC_LOW_RATE_OPTIMIZE_DROP = 4'h2;
  localparam logic [3:0] MSC_SF_RST = 4'h7;
  localparam logic [3:0] MSC_BW_RST = 4'h7;
  localparam logic [2:0] MSC_CR_RST = 3'h1;

  typedef struct packed {
    logic [3:0] spread_factor;
    logic [3:0] chirp_bandwidth;
    logic [2:0] fec_code_rate;
    logic low_rate_optimize;
  } msc_mod_t;

  // Bandwidths in units of 10 Hz, as printed in kHz with two decimals.
  function automatic longint msc_bw_10hz(input logic [3:0] code);
    unique case (code)
      4'h0: msc_bw_10hz = 781;
      4'h1: msc_bw_10hz = 1042;
      4'h2: msc_bw_10hz = 1563;
      4'h3: msc_bw_10hz = 2083;
      4'h4: msc_bw_10hz = 3125;
      4'h5: msc_bw_10hz = 4167;
      4'h6: msc_bw_10hz = 6250;
      4'h7: msc_bw_10hz = 12500;
      4'h8: msc_bw_10hz = 25000;
      default: msc_bw_10hz = 50000;
    endcase
  endfunction

  // Phase step of a 32-bit chip accumulator: one wrap per chip.
  function automatic logic [31:0] msc_bw_step(input logic [3:0] code);
    longint s;
    s = (msc_bw_10hz(code) * 10 * (64'sd1 <<< 32)) / MSC_CLK_HZ;
    msc_bw_step = s[31:0];
  endfunction
endpackage

// [rtl/msc_rate_gen.sv]
// Chip and symbol tick generator driven by a phase accumulator.
// Assumes step and spread factor are held stable between restart pulses.
`timescale 1ns/1ns
`default_nettype none
module msc_rate_gen
  import msc_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [31:0] step,
  input wire logic [3:0] spread_factor,
  output logic chip_tick_ff,
  output logic sym_tick_ff
);
  logic [31:0] acc_ff, nxt_acc;
  logic [CNT_W-1:0] chip_cnt_ff, nxt_chip_cnt;
  logic nxt_chip_tick, nxt_sym_tick;
  logic [CNT_W-1:0] last_chip;
  logic [32:0] sum;

  always_comb begin
    last_chip = CNT_W'((13'h1 << spread_factor) - 13'h1);
    sum = {1'b0, acc_ff} + {1'b0, step};
    nxt_acc = acc_ff;
    nxt_chip_cnt = chip_cnt_ff;
    nxt_chip_tick = 1'b0;
    nxt_sym_tick = 1'b0;
    if (!run || restart) begin
      nxt_acc = 32'h0;
      nxt_chip_cnt = '0;
    end else begin
      nxt_acc = sum[31:0];
      if (sum[32]) begin
        // One chip per second per hertz of bandwidth.
        nxt_chip_tick = 1'b1; // RL10
        if (chip_cnt_ff >= last_chip) begin
          nxt_chip_cnt = '0;
          nxt_sym_tick = 1'b1; // RL10
        end else begin
          nxt_chip_cnt = chip_cnt_ff + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= 32'h0;
      chip_cnt_ff <= '0;
      chip_tick_ff <= 1'b0;
      sym_tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      chip_cnt_ff <= nxt_chip_cnt;
      chip_tick_ff <= nxt_chip_tick;
      sym_tick_ff <= nxt_sym_tick;
    end
  end

  sym_on_chip_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    sym_tick_ff |-> chip_tick_ff) else $error("Symbol tick without chip tick.");
  sym_count_a: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    nxt_sym_tick |-> chip_cnt_ff == last_chip) else $error("Symbol not after 2^SF chips.");
endmodule // msc_rate_gen
`default_nettype wire

// [rtl/msc_modem_select.sv]
// Modem and frame selection with chirp modulation parameter storage.
// Assumes host commands arrive as one-cycle pulses on this clock with data valid alongside.
`timescale 1ns/1ns
`default_nettype none
module msc_modem_select
  import msc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_modem_cmd,
  input wire logic [1:0] pkt_type_in,
  input wire logic read_modem_cmd,
  input wire logic load_modulation_cmd,
  input wire msc_mod_t mod_in,
  input wire logic implicit_hdr_in,
  input wire logic rf_below_400m,
  input wire logic rx_active,
  input wire logic hdr_cr_valid,
  input wire logic [2:0] hdr_cr,
  output logic [1:0] pkt_type,
  output logic read_valid,
  output logic [1:0] read_type,
  output logic css_modem_en,
  output logic fsk_modem_en,
  output logic hop_mod_en,
  output logic pkt_handler_en,
  output var msc_mod_t mod_params,
  output logic implicit_hdr,
  output logic cmd_err,
  output logic [12:0] chips_per_sym,
  output logic [3:0] bits_per_sym,
  output logic [3:0] overhead_q,
  output logic [2:0] active_cr,
  output logic [2:0] header_cr,
  output logic zero_if,
  output logic chip_tick,
  output logic sym_tick
);
  logic [1:0] pkt_type_ff, nxt_pkt_type;
  logic read_valid_ff, nxt_read_valid;
  logic [1:0] read_type_ff, nxt_read_type;
  logic css_en_ff, nxt_css_en;
  logic fsk_en_ff, nxt_fsk_en;
  logic hop_en_ff, nxt_hop_en;
  logic handler_en_ff, nxt_handler_en;
  msc_mod_t mod_ff, nxt_mod;
  logic implicit_ff, nxt_implicit;
  logic err_ff, nxt_err;
  logic loaded_ff, nxt_loaded;
  logic mod_ok;
  logic type_ok;
  logic bw_ok;

  // Command decode: packet type selection and modulation load.
  always_comb begin
    type_ok = pkt_type_in != MSC_PT_NONE;
    bw_ok = mod_in.chirp_bandwidth <= MSC_BW_MAX; // RL11
    if (rf_below_400m && mod_in.chirp_bandwidth >= MSC_BW_LOW_LIMIT) begin
      bw_ok = 1'b0; // RL12
    end
    // Modulation is refused unless the chirp modem or the hopping modulator is selected.
    mod_ok = (pkt_type_ff == MSC_PT_CSS || pkt_type_ff == MSC_PT_HOP) // RL5
      && mod_in.spread_factor >= MSC_SF_MIN && mod_in.spread_factor <= MSC_SF_MAX // RL6
      && bw_ok
      && mod_in.fec_code_rate >= MSC_CR_MIN && mod_in.fec_code_rate <= MSC_CR_MAX; // RL14
    nxt_pkt_type = pkt_type_ff;
    nxt_mod = mod_ff;
    nxt_implicit = implicit_ff;
    nxt_err = err_ff;
    nxt_loaded = loaded_ff;
    nxt_read_valid = read_modem_cmd;
    nxt_read_type = read_type_ff;
    if (read_modem_cmd) begin
      nxt_read_type = pkt_type_ff; // RL3
    end
    if (select_modem_cmd) begin
      nxt_err = !type_ok;
      if (type_ok) begin
        nxt_pkt_type = pkt_type_in; // RL1
        nxt_loaded = 1'b0; // RL2
      end
    end else if (load_modulation_cmd) begin
      nxt_err = !mod_ok;
      if (mod_ok) begin
        // Implicit header is legal at every factor, five and six included.
        nxt_mod = mod_in; // RL7
        nxt_implicit = implicit_hdr_in; // RL7
        nxt_loaded = 1'b1;
      end
    end
    // Without a command nothing above changes except read_valid, which falls to zero.
    nxt_css_en = nxt_pkt_type == MSC_PT_CSS; // RL1
    nxt_fsk_en = nxt_pkt_type == MSC_PT_FSK; // RL1
    nxt_hop_en = nxt_pkt_type == MSC_PT_HOP; // RL4
    nxt_handler_en = nxt_css_en || nxt_fsk_en; // RL4
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pkt_type_ff <= MSC_PT_NONE;
      read_valid_ff <= 1'b0;
      read_type_ff <= MSC_PT_NONE;
      css_en_ff <= 1'b0;
      fsk_en_ff <= 1'b0;
      hop_en_ff <= 1'b0;
      handler_en_ff <= 1'b0;
      mod_ff <= '{MSC_SF_RST, MSC_BW_RST, MSC_CR_RST, 1'b0};
      implicit_ff <= 1'b0;
      err_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else begin
      pkt_type_ff <= nxt_pkt_type; // RL20
      read_valid_ff <= nxt_read_valid;
      read_type_ff <= nxt_read_type;
      css_en_ff <= nxt_css_en;
      fsk_en_ff <= nxt_fsk_en;
      hop_en_ff <= nxt_hop_en;
      handler_en_ff <= nxt_handler_en;
      mod_ff <= nxt_mod; // RL20
      implicit_ff <= nxt_implicit;
      err_ff <= nxt_err;
      loaded_ff <= nxt_loaded;
    end
  end

  // Derived figures, one cycle behind the stored parameters.
  logic [12:0] chips_ff, nxt_chips;
  logic [3:0] bits_ff, nxt_bits;
  logic [3:0] ovh_ff, nxt_ovh;
  logic [2:0] act_cr_ff, nxt_act_cr;
  logic [2:0] rx_cr_ff, nxt_rx_cr;
  logic zero_if_ff, nxt_zero_if;
  logic restart_ff, nxt_restart;
  logic [31:0] step_ff, nxt_step;
  // A constant, but held in a register so that every output leaves a flip-flop.
  logic [2:0] header_cr_ff;

  always_comb begin
    // The same factor serves transmit and receive; the far end must match it.
    nxt_chips = 13'h1 << mod_ff.spread_factor; // RL6 RL9
    nxt_bits = mod_ff.low_rate_optimize ? mod_ff.spread_factor - MSC_LOW_RATE_OPTIMIZE_DROP
      : mod_ff.spread_factor; // RL16
    nxt_ovh = {1'b0, mod_ff.fec_code_rate} + 4'h4; // RL14
    nxt_zero_if = mod_ff.chirp_bandwidth == MSC_BW_ZERO_IF; // RL13
    nxt_step = msc_bw_step(mod_ff.chirp_bandwidth); // RL10 RL11
    nxt_restart = mod_ff != nxt_mod;
    nxt_rx_cr = rx_cr_ff;
    if (hdr_cr_valid && hdr_cr >= MSC_CR_MIN && hdr_cr <= MSC_CR_MAX) begin
      nxt_rx_cr = hdr_cr; // RL15
    end
    // Explicit header in receive uses the rate carried by the header.
    nxt_act_cr = (rx_active && !implicit_ff) ? rx_cr_ff : mod_ff.fec_code_rate; // RL15
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chips_ff <= 13'h80;
      bits_ff <= MSC_SF_RST;
      ovh_ff <= 4'h5;
      act_cr_ff <= MSC_CR_RST;
      rx_cr_ff <= MSC_CR_RST;
      zero_if_ff <= 1'b0;
      restart_ff <= 1'b0;
      step_ff <= 32'h0;
      header_cr_ff <= MSC_HDR_CR;
    end else begin
      chips_ff <= nxt_chips;
      bits_ff <= nxt_bits;
      ovh_ff <= nxt_ovh;
      act_cr_ff <= nxt_act_cr;
      rx_cr_ff <= nxt_rx_cr;
      zero_if_ff <= nxt_zero_if;
      restart_ff <= nxt_restart;
      step_ff <= nxt_step;
      header_cr_ff <= MSC_HDR_CR; // RL19
    end
  end

  msc_rate_gen #(
    .CNT_W(12)
  ) u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .run(css_en_ff || hop_en_ff),
    .restart(restart_ff),
    .step(step_ff),
    .spread_factor(mod_ff.spread_factor),
    .chip_tick_ff(chip_tick),
    .sym_tick_ff(sym_tick)
  );

  assign pkt_type = pkt_type_ff;
  assign read_valid = read_valid_ff;
  assign read_type = read_type_ff;
  assign css_modem_en = css_en_ff;
  assign fsk_modem_en = fsk_en_ff;
  assign hop_mod_en = hop_en_ff;
  assign pkt_handler_en = handler_en_ff;
  assign mod_params = mod_ff;
  assign implicit_hdr = implicit_ff;
  assign cmd_err = err_ff;
  assign chips_per_sym = chips_ff;
  assign bits_per_sym = bits_ff;
  assign overhead_q = ovh_ff;
  assign active_cr = act_cr_ff;
  // The header itself always goes out at the strongest rate.
  assign header_cr = header_cr_ff; // RL19
  assign zero_if = zero_if_ff;

  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence good_load_s;
    load_modulation_cmd && !select_modem_cmd && mod_ok;
  endsequence
  // Derived checks look back at the command's own fields, so a second load in between
  // does not disturb them.
  sequence derived_s;
    ##2 chips_ff == (13'h1 << $past(mod_in.spread_factor, 2));
  endsequence

  select_apply_a: assert property (select_modem_cmd && type_ok |=> // RL1
    pkt_type_ff == $past(pkt_type_in) && handler_en_ff == !hop_en_ff)
    else $error("Packet type not applied.");
  read_reply_a: assert property (read_modem_cmd |=> read_valid_ff // RL3
    && read_type_ff == $past(pkt_type_ff)) else $error("Read reply wrong.");
  hop_handler_a: assert property (hop_en_ff |-> !handler_en_ff && !css_en_ff) // RL4
    else $error("Hopping mode has a handler.");
  sf_refuse_a: assert property (load_modulation_cmd && !select_modem_cmd // RL6
    && (mod_in.spread_factor < MSC_SF_MIN || mod_in.spread_factor > MSC_SF_MAX)
    |=> err_ff && $stable(mod_ff)) else $error("Bad spread factor taken.");
  chips_track_a: assert property (good_load_s |-> derived_s) // RL6
    else $error("Chip count not 2^SF.");
  low_band_a: assert property (load_modulation_cmd && !select_modem_cmd // RL12
    && rf_below_400m && mod_in.chirp_bandwidth >= MSC_BW_LOW_LIMIT |=> err_ff)
    else $error("High bandwidth taken below 400 MHz.");
  low_rate_optimize_bits_a: assert property (good_load_s |-> ##2 bits_ff == // RL16
    ($past(mod_in.low_rate_optimize, 2) ? $past(mod_in.spread_factor, 2) - 4'h2
    : $past(mod_in.spread_factor, 2))) else $error("Bits per symbol wrong.");
  zero_if_a: assert property (good_load_s |-> ##2 // RL13
    zero_if_ff == ($past(mod_in.chirp_bandwidth, 2) == 4'h9)) else $error("IF mode wrong.");
  overhead_a: assert property (good_load_s |-> ##2 // RL14
    ovh_ff == {1'b0, $past(mod_in.fec_code_rate, 2)} + 4'h4) else $error("Overhead wrong.");
  rx_cr_a: assert property (rx_active && !implicit_ff |=> // RL15
    act_cr_ff == $past(rx_cr_ff)) else $error("Receive rate not from header.");
  hold_a: assert property (!select_modem_cmd && !load_modulation_cmd |=> // RL20
    $stable(mod_ff) && $stable(pkt_type_ff)) else $error("Settings drifted.");

  // A refused command must raise the flag and leave every stored setting as it was.
  sequence bad_load_s;
    load_modulation_cmd && !select_modem_cmd && !mod_ok;
  endsequence
  refuse_keep_a: assert property (bad_load_s |=> err_ff && $stable(mod_ff) // RL20
    && $stable(implicit_ff)) else $error("Refused load changed settings.");
  type_refuse_a: assert property (select_modem_cmd && !type_ok |=> // RL1
    err_ff && $stable(pkt_type_ff)) else $error("Unknown packet type taken.");
  type_clear_a: assert property (select_modem_cmd && type_ok |=> !err_ff) // RL1
    else $error("Good select left the error flag.");
  one_modem_a: assert property ($onehot0({css_en_ff, fsk_en_ff, hop_en_ff})) // RL1
    else $error("More than one modem enabled.");
  no_type_a: assert property (pkt_type_ff == MSC_PT_NONE |-> !handler_en_ff // RL1
    && !css_en_ff && !fsk_en_ff && !hop_en_ff) else $error("Modem on with no type.");
  handler_on_a: assert property (fsk_en_ff || css_en_ff |-> handler_en_ff) // RL4
    else $error("Packet handler missing.");
  mode_refuse_a: assert property (load_modulation_cmd && !select_modem_cmd // RL5
    && pkt_type_ff != MSC_PT_CSS && pkt_type_ff != MSC_PT_HOP |=> err_ff && $stable(mod_ff))
    else $error("Load taken without a chirp modem.");
  load_apply_a: assert property (good_load_s |=> !err_ff // RL5
    && mod_ff == $past(mod_in)) else $error("Good load not stored.");
  implicit_a: assert property (good_load_s |=> // RL7
    implicit_ff == $past(implicit_hdr_in)) else $error("Header mode not stored.");
  bw_refuse_a: assert property (load_modulation_cmd && !select_modem_cmd // RL11
    && mod_in.chirp_bandwidth > MSC_BW_MAX |=> err_ff) else $error("Bandwidth code taken.");
  cr_refuse_a: assert property (load_modulation_cmd && !select_modem_cmd // RL14
    && (mod_in.fec_code_rate < MSC_CR_MIN || mod_in.fec_code_rate > MSC_CR_MAX)
    |=> err_ff && $stable(mod_ff)) else $error("Bad code rate taken.");

  // Derived figures never leave the ranges that legal settings can give.
  chips_range_a: assert property (chips_ff >= 13'h20 && chips_ff <= 13'h1000) // RL6
    else $error("Chip count out of range.");
  bits_range_a: assert property (bits_ff >= 4'h3 && bits_ff <= MSC_SF_MAX) // RL16
    else $error("Bits per symbol out of range.");
  ovh_range_a: assert property (ovh_ff >= 4'h5 && ovh_ff <= 4'h8) // RL14
    else $error("Overhead out of range.");
  hdr_latch_a: assert property (hdr_cr_valid && hdr_cr >= MSC_CR_MIN // RL15
    && hdr_cr <= MSC_CR_MAX |=> rx_cr_ff == $past(hdr_cr)) else $error("Header rate lost.");
  rx_cr_hold_a: assert property (!hdr_cr_valid |=> $stable(rx_cr_ff)) // RL15
    else $error("Header rate drifted.");
  own_cr_a: assert property (!(rx_active && !implicit_ff) |=> // RL15
    act_cr_ff == $past(mod_ff.fec_code_rate)) else $error("Stored rate not used.");
  read_idle_a: assert property (!read_modem_cmd |=> !read_valid_ff) // RL3
    else $error("Read reply without request.");
  read_hold_a: assert property (!read_modem_cmd |=> $stable(read_type_ff)) // RL3
    else $error("Read type drifted.");
  // A stale phase would stretch the first symbol after a change of settings.
  restart_a: assert property (mod_ff != nxt_mod |=> restart_ff) // RL10
    else $error("Rate not restarted on new settings.");
  tick_idle_a: assert property (!css_en_ff && !hop_en_ff |=> !chip_tick && !sym_tick) // RL10
    else $error("Ticks while no chirp modem runs.");
endmodule // msc_modem_select
`default_nettype wire

// [test/msc_host_model.sv]
// Host controller model that issues select, read and load command pulses.
// Assumes the block samples commands on the rising clock edge, one pulse per cycle.
`timescale 1ns/1ns
`default_nettype none
module msc_host_model
  import msc_pkg::*;
(
  input wire logic clk,
  output logic select_modem_cmd,
  output logic [1:0] pkt_type_in,
  output logic read_modem_cmd,
  output logic load_modulation_cmd,
  output var msc_mod_t mod_in,
  output logic implicit_hdr_in
);
  initial begin
    select_modem_cmd = 1'b0;
    pkt_type_in = 2'h0;
    read_modem_cmd = 1'b0;
    load_modulation_cmd = 1'b0;
    mod_in = '0;
    implicit_hdr_in = 1'b0;
  end

  // Released data lines show the inverse so stale values are never mistaken for fresh ones.
  task automatic do_select(input logic [1:0] t);
    @(posedge clk);
    select_modem_cmd <= 1'b1;
    pkt_type_in <= t;
    @(posedge clk);
    select_modem_cmd <= 1'b0;
    pkt_type_in <= ~t;
  endtask

  task automatic do_read();
    @(posedge clk);
    read_modem_cmd <= 1'b1;
    @(posedge clk);
    read_modem_cmd <= 1'b0;
  endtask

  task automatic do_load(input msc_mod_t m, input logic im);
    @(posedge clk);
    load_modulation_cmd <= 1'b1;
    mod_in <= m;
    implicit_hdr_in <= im;
    @(posedge clk);
    load_modulation_cmd <= 1'b0;
    mod_in <= ~m;
    implicit_hdr_in <= ~im;
  endtask
endmodule // msc_host_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the modem select block, driving it through the host model.
// Assumes a 100 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import msc_pkg::*;
  logic clk, rst_n, select_modem_cmd, read_modem_cmd, load_modulation_cmd, implicit_hdr_in;
  logic rf_below_400m, rx_active, hdr_cr_valid, read_valid, css_modem_en, fsk_modem_en;
  logic hop_mod_en, pkt_handler_en, implicit_hdr, cmd_err, zero_if, chip_tick, sym_tick;
  logic [1:0] pkt_type_in, pkt_type, read_type;
  logic [2:0] hdr_cr, active_cr, header_cr;
  logic [3:0] bits_per_sym, overhead_q;
  logic [12:0] chips_per_sym;
  msc_mod_t mod_in, mod_params;
  int err_total = 0;
  int n_compared = 0;

  msc_modem_select uut (.clk, .rst_n, .select_modem_cmd, .pkt_type_in, .read_modem_cmd,
    .load_modulation_cmd, .mod_in, .implicit_hdr_in, .rf_below_400m, .rx_active,
    .hdr_cr_valid, .hdr_cr, .pkt_type, .read_valid, .read_type, .css_modem_en,
    .fsk_modem_en, .hop_mod_en, .pkt_handler_en, .mod_params, .implicit_hdr, .cmd_err,
    .chips_per_sym, .bits_per_sym, .overhead_q, .active_cr, .header_cr, .zero_if,
    .chip_tick, .sym_tick);
  msc_host_model host (.clk, .select_modem_cmd, .pkt_type_in, .read_modem_cmd,
    .load_modulation_cmd, .mod_in, .implicit_hdr_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Loads and waits until the derived outputs, which lag by one more cycle, have settled.
  task automatic load(input logic [3:0] sf, bw, input logic [2:0] cr, input logic ld, im);
    host.do_load('{sf, bw, cr, ld}, im);
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    #1;
    chk("pkt_type", 2'h2, pkt_type);
    chk("enables", 4'h0, {css_modem_en, fsk_modem_en, hop_mod_en, pkt_handler_en});
    chk("mod_params", {4'h7, 4'h7, 3'h1, 1'b0}, mod_params);
    chk("chips", 13'd128, chips_per_sym);
    chk("overhead", 4'h5, overhead_q);
    chk("header_cr", 3'h4, header_cr);
  endtask

  task automatic t_select();
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      t = i[1:0];
      host.do_select(t);
      #1;
      if (t != 2'h2) begin
        chk("pkt_type", t, pkt_type);
        chk("css_en", t == 2'h1, css_modem_en);
        chk("fsk_en", t == 2'h0, fsk_modem_en);
        chk("hop_en", t == 2'h3, hop_mod_en);
        chk("handler_en", t != 2'h3, pkt_handler_en);
      end
      chk("cmd_err", t == 2'h2, cmd_err);
      host.do_read();
      #1;
      chk("read_valid", 1'b1, read_valid);
      chk("read_type", (t == 2'h2) ? 2'h1 : t, read_type);
      @(posedge clk);
      #1;
      chk("read_valid_end", 1'b0, read_valid);
    end
  endtask

  task automatic t_sf();
    logic ok;
    host.do_select(2'h0);
    load(4'h9, 4'h7, 3'h1, 1'b0, 1'b0);
    chk("fsk_load_err", 1'b1, cmd_err);
    host.do_select(2'h1);
    for (int sf = 4; sf < 14; sf++) begin
      ok = (sf >= 5) && (sf <= 12);
      load(sf[3:0], 4'h7, 3'h1, 1'b0, 1'b0);
      chk("sf_err", !ok, cmd_err);
      if (ok) chk("chips", 1 << sf, chips_per_sym);
      if (ok) chk("bits", sf, bits_per_sym);
    end
    chk("sf_held", 4'hC, mod_params.spread_factor);
    load(4'hC, 4'h7, 3'h1, 1'b1, 1'b0);
    chk("bits_low_rate_optimize", 4'hA, bits_per_sym);
    load(4'h5, 4'h7, 3'h1, 1'b0, 1'b1);
    chk("implicit_sf5", 1'b1, implicit_hdr);
  endtask

  task automatic t_bw();
    for (int bw = 0; bw < 11; bw++) begin
      load(4'h7, bw[3:0], 3'h1, 1'b0, 1'b0);
      chk("bw_err", bw > 9, cmd_err);
      if (bw <= 9) chk("zero_if", bw == 9, zero_if);
    end
    rf_below_400m <= 1'b1;
    load(4'h7, 4'h7, 3'h1, 1'b0, 1'b0);
    chk("low_bw7_err", 1'b0, cmd_err);
    load(4'h7, 4'h8, 3'h1, 1'b0, 1'b0);
    chk("low_bw8_err", 1'b1, cmd_err);
    chk("bw_held", 4'h7, mod_params.chirp_bandwidth);
    rf_below_400m <= 1'b0;
  endtask

  task automatic t_cr();
    for (int cr = 0; cr < 6; cr++) begin
      load(4'h7, 4'h7, cr[2:0], 1'b0, 1'b0);
      chk("cr_err", cr < 1 || cr > 4, cmd_err);
      if (cr >= 1 && cr <= 4) chk("overhead", cr + 4, overhead_q);
    end
    load(4'h6, 4'h7, 3'h1, 1'b0, 1'b0);
    rx_active <= 1'b1;
    hdr_cr <= 3'h3;
    hdr_cr_valid <= 1'b1;
    @(posedge clk);
    hdr_cr_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("active_cr_hdr", 3'h3, active_cr);
    load(4'h6, 4'h7, 3'h1, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk("active_cr_impl", 3'h1, active_cr);
    rx_active <= 1'b0;
  endtask

  task automatic t_rate();
    int n;
    int c;
    load(4'h5, 4'h9, 3'h1, 1'b0, 1'b0);
    n = 0;
    while (sym_tick !== 1'b1 && n < 8000) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    c = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (chip_tick === 1'b1) c++;
    end while (sym_tick !== 1'b1 && n < 8000);
    // A 500 kHz bandwidth over 32 chips gives one symbol per 6400 cycles.
    chk("sym_period_ok", 1'b1, n >= 6399 && n <= 6401);
    chk("chip_ticks_per_sym", 32'd32, c);
    // With the FSK modem selected the chirp timing must fall silent.
    host.do_select(2'h0);
    @(posedge clk);
    c = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (chip_tick !== 1'b0 || sym_tick !== 1'b0) c++;
    end
    chk("fsk_ticks", 32'd0, c);
  endtask

  initial begin
    rst_n = 1'b0;
    rf_below_400m = 1'b0;
    rx_active = 1'b0;
    hdr_cr_valid = 1'b0;
    hdr_cr = 3'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b0;
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_select();
    t_sf();
    t_bw();
    t_cr();
    t_rate();
    end_sim();
  end

  initial begin
    #500_000;
    err_total++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
